//--- hw/drt_map.svh
// Register map and constants for the dual reload timer block
// Assumes byte-addressed APB with one 32-bit word per register
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH
// Per-timer register offsets (timer 2 adds DRT_T2_BASE)
`define DRT_OFS_CTRL 12'h000
`define DRT_OFS_COUNT 12'h004
`define DRT_OFS_RELA 12'h008
`define DRT_OFS_RELB 12'h00C
`define DRT_T1_BASE 12'h000
`define DRT_T2_BASE 12'h010
`define DRT_OFS_HSTS 12'h020
// Control and fast-select register fields, reset values and count constants
`define DRT_B_RUN 0
`define DRT_B_MLO 1
`define DRT_B_MMID 2
`define DRT_B_MHI 3
`define DRT_B_PNDA 4
`define DRT_B_ENA 5
`define DRT_B_PNDB 6
`define DRT_B_ENB 7
`define DRT_B_FAST 0
`define DRT_HSTS_RST 8'h00
`define DRT_CTRL_RST 8'h00
`define DRT_CNT_RST 16'h0000
`define DRT_CNT_ONE 16'h0001
`define DRT_CNT_ZERO 16'h0000
// Rate dividers: instruction rate is 1/10, doubled internal rate 1/1
`define DRT_DIV_SLOW 4'd10
`define DRT_DIV_ONE 4'd1
`endif

//--- hw/drt_pkg.sv
// Types for the dual reload timer block
// Assumes nothing of its surroundings
package drt_pkg;
    typedef enum logic [1:0] {
        DRT_PWM = 2'b00,
        DRT_EVENT = 2'b01,
        DRT_CAPTURE = 2'b10
    } drt_mode_t;
endpackage

//--- hw/drt_timer.sv
// Dual 16-bit reload/capture timer with APB register access
// Assumes pins are asynchronous to pclk; pclk is the internal clock
//
// Operation
// - Each timer has a 16-bit down-counter and two reload/capture regs
// - Three modes, PWM, event count, capture, chosen by three mode bits
// - Fast-select bit 0 clocks timer 2 at the doubled rate; resets 00
// - Timer 1 always counts at the instruction-cycle rate
// - PWM counts down and reloads alternately from A and B on underflow
// - First PWM underflow loads from A, then alternates starting with B
// - PWM underflow may toggle pin A per mode; underflows may interrupt
// - PWM underflows set pending A and B alternately; software clears
// - Reload-A underflow interrupts with enable A, reload-B with enable B
// - Event mode counts selected edge of synchronised pin A
// - Event mode underflow sets pending A, interrupts with enable A
// - Event mode rising edge of pin B sets pending B
// - Event mode produces no PWM output on pin A
// - Capture mode counter runs free; A pairs with pin A, B with pin B
// - Capture copies count on chosen edge of each pin independently
// - Each capture sets its pin's pending flag and may interrupt
// - Capture underflow sets the run bit as underflow pending, via A
// - Reading a capture register does not disturb the count
// - In PWM and event modes the run bit starts and stops the counter
// - Mode encoding: 101/100 PWM, 000/001 event, x1x capture edges
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "drt_map.svh"
`timescale 1ns/10ps
`default_nettype none

module drt_timer
    import drt_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] timer_pin_a_in,
    input wire logic [1:0] timer_pin_b_in,
    output logic [1:0] timer_pin_a_out,
    output logic [1:0] timer_pin_a_oe,
    output logic [1:0] irq_a,
    output logic [1:0] irq_b
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic [WIDTH-1:0] count [2];
    logic [WIDTH-1:0] reload_capture_a [2];
    logic [WIDTH-1:0] reload_capture_b [2];
    logic [7:0] ctrl [2];
    logic [7:0] high_speed_timer_select;
    logic [2:0] sync_a [2];
    logic [2:0] sync_b [2];
    logic [1:0] level_a;
    logic [1:0] level_b;
    logic [1:0] pwm_first;
    logic [1:0] next_is_b;
    logic [3:0] div_cnt;
    logic slow_tick;
    logic [1:0] tick;

    // Writes land at the access edge, which is also the edge of pready
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // ------------------------------------------------------------
    // Rate enables
    // ------------------------------------------------------------
    // One divider serves both timers, so their slow ticks stay aligned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 4'd0;
            slow_tick <= 1'b0;
        end else if (div_cnt == `DRT_DIV_SLOW - `DRT_DIV_ONE) begin
            div_cnt <= 4'd0;
            slow_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + `DRT_DIV_ONE;
            slow_tick <= 1'b0;
        end
    end

    always_comb begin
        // Timer 2 ticks on every pclk when fast; timer 1 never does
        tick[0] = slow_tick;
        tick[1] = high_speed_timer_select[`DRT_B_FAST] ? 1'b1
                                                       : slow_tick;
    end

    // ------------------------------------------------------------
    // Fast-select register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_speed_timer_select <= `DRT_HSTS_RST;
        end else if (wr_en && paddr == `DRT_OFS_HSTS) begin
            high_speed_timer_select <= {7'd0, pwdata[`DRT_B_FAST]};
        end
    end

    // ------------------------------------------------------------
    // Per-timer logic
    // ------------------------------------------------------------
    for (genvar t = 0; t < 2; t++) begin : g_tmr
        localparam logic [11:0] BASE = (t == 0) ? `DRT_T1_BASE
                                                : `DRT_T2_BASE;
        logic [2:0] mode_bits;
        drt_mode_t mode;
        logic edge_a_rise;
        logic edge_a_fall;
        logic edge_b_rise;
        logic edge_b_fall;
        logic cnt_en;
        logic uflow;
        logic cap_a;
        logic cap_b;
        logic wr_ctrl;
        logic set_pnda;
        logic set_pndb;
        logic set_run;
        logic wr_count;
        logic wr_rela;
        logic wr_relb;

        assign mode_bits = {ctrl[t][`DRT_B_MHI], ctrl[t][`DRT_B_MMID],
                            ctrl[t][`DRT_B_MLO]};
        assign wr_ctrl = wr_en && paddr == BASE + `DRT_OFS_CTRL;
        assign wr_count = wr_en && paddr == BASE + `DRT_OFS_COUNT;
        assign wr_rela = wr_en && paddr == BASE + `DRT_OFS_RELA;
        assign wr_relb = wr_en && paddr == BASE + `DRT_OFS_RELB;

        // ------------------------------------------------------------
        // Mode decode
        // ------------------------------------------------------------
        always_comb begin
            if (mode_bits[1]) begin
                mode = DRT_CAPTURE;
            end else if (mode_bits[2]) begin
                mode = DRT_PWM;
            end else begin
                mode = DRT_EVENT;
            end
        end

        // ------------------------------------------------------------
        // Pin synchronisers; second and third stages compared for edges
        // ------------------------------------------------------------
        // The first stage may go metastable; only the shift reads it
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_a[t] <= 3'b000;
                sync_b[t] <= 3'b000;
            end else begin
                sync_a[t] <= {sync_a[t][1:0], timer_pin_a_in[t]};
                sync_b[t] <= {sync_b[t][1:0], timer_pin_b_in[t]};
            end
        end

        // ------------------------------------------------------------
        // Edges are seen at the selected counting rate
        // ------------------------------------------------------------
        // Levels update only on ticks, so a slow timer misses pulses
        // shorter than one tick; pins must hold for a full tick
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                level_a[t] <= 1'b0;
                level_b[t] <= 1'b0;
            end else if (tick[t] && sync_a[t][2] == sync_a[t][1]
                         && sync_b[t][2] == sync_b[t][1]) begin
                level_a[t] <= sync_a[t][2];
                level_b[t] <= sync_b[t][2];
            end else if (tick[t] && sync_a[t][2] == sync_a[t][1]) begin
                level_a[t] <= sync_a[t][2];
            end else if (tick[t] && sync_b[t][2] == sync_b[t][1]) begin
                level_b[t] <= sync_b[t][2];
            end
        end

        always_comb begin
            edge_a_rise = tick[t] && sync_a[t][2] && sync_a[t][1]
                          && !level_a[t];
            edge_a_fall = tick[t] && !sync_a[t][2] && !sync_a[t][1]
                          && level_a[t];
            edge_b_rise = tick[t] && sync_b[t][2] && sync_b[t][1]
                          && !level_b[t];
            edge_b_fall = tick[t] && !sync_b[t][2] && !sync_b[t][1]
                          && level_b[t];
        end

        // ------------------------------------------------------------
        // Count enable, underflow and flag events
        // ------------------------------------------------------------
        always_comb begin
            case (mode)
                DRT_PWM: begin
                    cnt_en = tick[t] && ctrl[t][`DRT_B_RUN];
                end
                DRT_EVENT: begin
                    cnt_en = ctrl[t][`DRT_B_RUN]
                             && (mode_bits[0] ? edge_a_fall
                                              : edge_a_rise);
                end
                DRT_CAPTURE: begin
                    cnt_en = tick[t];
                end
                default: begin
                    cnt_en = 1'b0;
                end
            endcase
            uflow = cnt_en && count[t] == `DRT_CNT_ZERO;
            cap_a = mode == DRT_CAPTURE
                    && (mode_bits[0] ? edge_a_fall : edge_a_rise);
            cap_b = mode == DRT_CAPTURE
                    && (mode_bits[2] ? edge_b_fall : edge_b_rise);
            set_pnda = (mode == DRT_PWM && uflow && !next_is_b[t])
                       || (mode == DRT_EVENT && uflow)
                       || cap_a;
            set_pndb = (mode == DRT_PWM && uflow && next_is_b[t])
                       || (mode == DRT_EVENT && edge_b_rise)
                       || cap_b;
            set_run = mode == DRT_CAPTURE && uflow;
        end

        // ------------------------------------------------------------
        // Counter: software writes win over reload and count; capture reads leave it alone
        // ------------------------------------------------------------
        // In capture mode the count wraps through zero, no reload
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                count[t] <= `DRT_CNT_RST;
            end else if (wr_count) begin
                count[t] <= pwdata[WIDTH-1:0];
            end else if (uflow && mode != DRT_CAPTURE) begin
                count[t] <= next_is_b[t] ? reload_capture_b[t]
                                         : reload_capture_a[t];
            end else if (cnt_en) begin
                count[t] <= count[t] - `DRT_CNT_ONE;
            end
        end

        // ------------------------------------------------------------
        // Reload alternation: first reload from A after start
        // ------------------------------------------------------------
        // Stopping or leaving PWM rearms the A-first order
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                next_is_b[t] <= 1'b0;
                pwm_first[t] <= 1'b1;
            end else if (!ctrl[t][`DRT_B_RUN] || mode != DRT_PWM) begin
                next_is_b[t] <= 1'b0;
                pwm_first[t] <= 1'b1;
            end else if (uflow) begin
                next_is_b[t] <= !next_is_b[t];
                pwm_first[t] <= 1'b0;
            end
        end

        // ------------------------------------------------------------
        // Reload/capture registers
        // ------------------------------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                reload_capture_a[t] <= `DRT_CNT_RST;
            end else if (cap_a) begin
                reload_capture_a[t] <= count[t];
            end else if (wr_rela) begin
                reload_capture_a[t] <= pwdata[WIDTH-1:0];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                reload_capture_b[t] <= `DRT_CNT_RST;
            end else if (cap_b) begin
                reload_capture_b[t] <= count[t];
            end else if (wr_relb) begin
                reload_capture_b[t] <= pwdata[WIDTH-1:0];
            end
        end

        // ------------------------------------------------------------
        // Control register; hardware sets win over software writes
        // ------------------------------------------------------------
        // A write in the same cycle as a hardware set loses that bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctrl[t] <= `DRT_CTRL_RST;
            end else begin
                if (wr_ctrl) begin
                    ctrl[t] <= pwdata[7:0];
                end
                if (set_pnda) begin
                    ctrl[t][`DRT_B_PNDA] <= 1'b1;
                end
                if (set_pndb) begin
                    ctrl[t][`DRT_B_PNDB] <= 1'b1;
                end
                if (set_run) begin
                    ctrl[t][`DRT_B_RUN] <= 1'b1;
                end
            end
        end

        // ------------------------------------------------------------
        // Pin A output and interrupt outputs
        // ------------------------------------------------------------
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                timer_pin_a_out[t] <= 1'b0;
                timer_pin_a_oe[t] <= 1'b0;
                irq_a[t] <= 1'b0;
                irq_b[t] <= 1'b0;
            end else begin
                timer_pin_a_oe[t] <= mode == DRT_PWM;
                if (mode == DRT_PWM && mode_bits[0] && uflow) begin
                    timer_pin_a_out[t] <= !timer_pin_a_out[t];
                end
                irq_a[t] <= ctrl[t][`DRT_B_ENA]
                            && (ctrl[t][`DRT_B_PNDA]
                                || (mode == DRT_CAPTURE
                                    && ctrl[t][`DRT_B_RUN]));
                irq_b[t] <= ctrl[t][`DRT_B_ENB]
                            && ctrl[t][`DRT_B_PNDB];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path: zero-wait answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Data and error are latched in setup and stand with pready
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    `DRT_OFS_CTRL: prdata <= {24'd0, ctrl[0]};
                    `DRT_OFS_COUNT: prdata <= {16'd0, count[0]};
                    `DRT_OFS_RELA: prdata <= {16'd0, reload_capture_a[0]};
                    `DRT_OFS_RELB: prdata <= {16'd0, reload_capture_b[0]};
                    `DRT_T2_BASE + `DRT_OFS_CTRL: prdata <= {24'd0, ctrl[1]};
                    `DRT_T2_BASE + `DRT_OFS_COUNT: prdata <= {16'd0, count[1]};
                    `DRT_T2_BASE + `DRT_OFS_RELA:
                        prdata <= {16'd0, reload_capture_a[1]};
                    `DRT_T2_BASE + `DRT_OFS_RELB:
                        prdata <= {16'd0, reload_capture_b[1]};
                    `DRT_OFS_HSTS: prdata <= {24'd0, high_speed_timer_select};
                    default: begin
                        prdata <= 32'h0000_0000;
                        pslverr <= !rd_en;
                    end
                endcase
            end
        end
    end

endmodule // drt_timer
`default_nettype wire

//--- tb/drt_timer_assertions.sv
// Port checker for the dual reload timer
// Assumes it is bound to drt_timer; one pclk domain
`timescale 1ns/10ps
`default_nettype none
module drt_timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] timer_pin_a_out,
    input wire logic [1:0] timer_pin_a_oe,
    input wire logic [1:0] irq_a,
    input wire logic [1:0] irq_b
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Timer 1 mode as last written
    logic [2:0] mode1;
    logic evt;
    logic pwm;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode1 <= 3'b000;
        end else if (pready && pwrite && paddr == 12'h000) begin
            mode1 <= pwdata[3:1];
        end
    end
    assign evt = mode1[2:1] == 2'b00;
    assign pwm = mode1[2:1] == 2'b10;
    AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_READY_PULSE: assert property (
        pready |-> psel && penable ##1 !pready)
        else $error("pready outside one access cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_ZERO: assert property (
        pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_UPPER_ZERO: assert property (
        pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_FAST_BITS: assert property (
        pready && !pwrite && paddr == 12'h020
        |-> prdata[31:1] == 31'h0000_0000)
        else $error("fast select spare bits set");
    AST_T1_SLOW: assert property (
        $changed(timer_pin_a_out[0]) && timer_pin_a_oe[0]
        |=> (!$changed(timer_pin_a_out[0]) || !timer_pin_a_oe[0]) [*8])
        else $error("timer 1 toggles faster than its rate");
    AST_EVT_NO_OE: assert property (
        evt && $past(evt) |-> !timer_pin_a_oe[0])
        else $error("pin A driven in event mode");
    AST_PWM_OE: assert property (
        pwm && $past(pwm) |-> timer_pin_a_oe[0])
        else $error("pin A not driven in pwm mode");
    cover property (pslverr);
    cover property ($rose(irq_a[0]));
    cover property ($rose(irq_b[0]));
    cover property ($rose(irq_a[1]));
endmodule // drt_timer_chk
bind drt_timer drt_timer_chk drt_timer_chk_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_pin_a_out, .timer_pin_a_oe, .irq_a, .irq_b);
`default_nettype wire

//--- tb/drt_pin_model.sv
// Pin-side model driving both pins of each timer
// Assumes pclk paces every pin change
`timescale 1ns/10ps
`default_nettype none
module drt_pin_model (
    input wire logic pclk,
    input wire logic [1:0] pin_a_out,
    input wire logic [1:0] pin_a_oe,
    output logic [1:0] pin_a_in,
    output logic [1:0] pin_b_in
);
    logic [1:0] drv_a = 2'b00;
    initial pin_b_in = 2'b00;
    // Pin A follows the timer while it drives, else the model
    assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & drv_a);
    // Each level held long enough for the slow rate to see it
    task set_a(input int t, input logic v);
        @(posedge pclk);
        drv_a[t] <= v;
        repeat (30) @(posedge pclk);
    endtask
    task set_b(input int t, input logic v);
        @(posedge pclk);
        pin_b_in[t] <= v;
        repeat (30) @(posedge pclk);
    endtask
endmodule // drt_pin_model
`default_nettype wire

//--- tb/drt_timer_tb.sv
// Testbench for the dual reload timer
// Assumes drt_timer, drt_pin_model and the bound checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module drt_timer_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] pa_in, pb_in, pa_out, pa_oe, irq_a, irq_b;
    logic [31:0] rd, c1, cap;
    logic err;
    int fail_count = 0;
    int checked = 0;
    always #12.5 pclk = ~pclk;
    drt_timer #(.WIDTH(16)) drt_timer_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .timer_pin_a_in(pa_in), .timer_pin_b_in(pb_in),
        .timer_pin_a_out(pa_out), .timer_pin_a_oe(pa_oe), .irq_a, .irq_b);
    drt_pin_model drt_pin_model_i (.pclk, .pin_a_out(pa_out),
        .pin_a_oe(pa_oe), .pin_a_in(pa_in), .pin_b_in(pb_in));
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) fail_count++;
    endtask
    task automatic wait_irq(input int t, input logic b);
        int k;
        k = 0;
        while ((b ? irq_b[t] : irq_a[t]) !== 1'b1 && k < 400) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 400) fail_count++;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h020, 0);
        `CHK("fast rst", 32'h0000_0000, rd)
        apb(0, 12'h024, 0);
        `CHK("unmapped err", 1'b1, err)
        $display("test reset done");
        apb(1, 12'h008, 2);
        apb(1, 12'h00C, 3);
        apb(1, 12'h004, 1);
        apb(1, 12'h000, 32'h0000_00AB);
        wait_irq(0, 0);
        apb(0, 12'h004, 0);
        `CHK("reload a", 32'h0000_0002, rd)
        apb(0, 12'h000, 0);
        `CHK("pend a", 32'h0000_0010, rd & 32'h0000_0050)
        `CHK("pin toggled", 1'b1, pa_out[0])
        apb(1, 12'h000, 32'h0000_00AB);
        wait_irq(0, 1);
        apb(0, 12'h004, 0);
        `CHK("reload b", 32'h0000_0003, rd)
        apb(0, 12'h000, 0);
        `CHK("pend b", 32'h0000_0040, rd & 32'h0000_0050)
        `CHK("pin back", 1'b0, pa_out[0])
        apb(1, 12'h000, 32'h0000_000A);
        apb(0, 12'h004, 0);
        c1 = rd;
        repeat (30) @(posedge pclk);
        apb(0, 12'h004, 0);
        `CHK("halted", c1, rd)
        $display("test pwm done");
        for (int p = 0; p < 2; p++) begin
            apb(1, 12'h004, 1);
            apb(1, 12'h000, 32'h0000_0021 | 32'(p << 1));
            drt_pin_model_i.set_a(0, 1'b1);
            apb(0, 12'h004, 0);
            `CHK("edge sel", 32'(p), rd)
            drt_pin_model_i.set_a(0, 1'b0);
            apb(0, 12'h004, 0);
            `CHK("event count", 32'h0000_0000, rd)
            drt_pin_model_i.set_a(0, 1'b1);
            drt_pin_model_i.set_a(0, 1'b0);
            apb(0, 12'h000, 0);
            `CHK("event under", 32'h0000_0010, rd & 32'h0000_0010)
            `CHK("irq a", 1'b1, irq_a[0])
        end
        drt_pin_model_i.set_b(0, 1'b1);
        drt_pin_model_i.set_b(0, 1'b0);
        apb(0, 12'h000, 0);
        `CHK("pin b pend", 32'h0000_0040, rd & 32'h0000_0040)
        `CHK("irq b masked", 1'b0, irq_b[0])
        `CHK("no pwm out", 1'b0, pa_oe[0])
        $display("test event done");
        apb(1, 12'h020, 1);
        apb(0, 12'h020, 0);
        `CHK("fast set", 32'h0000_0001, rd)
        apb(1, 12'h018, 0);
        apb(1, 12'h014, 32'h0000_8000);
        apb(1, 12'h010, 32'h0000_0024);
        apb(0, 12'h014, 0);
        c1 = rd;
        apb(0, 12'h014, 0);
        `CHK("free run", 1'b1, rd < c1)
        drt_pin_model_i.set_a(1, 1'b1);
        apb(0, 12'h010, 0);
        `CHK("cap pend", 32'h0000_0010, rd & 32'h0000_0050)
        `CHK("cap irq", 1'b1, irq_a[1])
        apb(0, 12'h018, 0);
        cap = rd;
        apb(0, 12'h014, 0);
        `CHK("cap value", 1'b1, cap < c1 && cap > rd)
        apb(0, 12'h018, 0);
        `CHK("cap kept", cap, rd)
        for (int q = 0; q < 2; q++) begin
            apb(1, 12'h010, 32'h0000_0024 | 32'(q << 3));
            drt_pin_model_i.set_b(1, 1'b1);
            apb(0, 12'h010, 0);
            `CHK("b edge", 32'((1 - q) << 6), rd & 32'h0000_0040)
            drt_pin_model_i.set_b(1, 1'b0);
        end
        apb(1, 12'h010, 32'h0000_0024);
        apb(1, 12'h014, 32'h0000_0020);
        repeat (60) @(posedge pclk);
        apb(0, 12'h010, 0);
        `CHK("cap under", 32'h0000_0001, rd & 32'h0000_0011)
        `CHK("under irq", 1'b1, irq_a[1])
        $display("test capture done");
        wrap_up();
    end
endmodule // drt_timer_tb
`default_nettype wire
